// ===== rtl/serial_eeprom_autoloader.sv
// Serial memory autoloader with software word access over Avalon-MM
// How it works
// - Four memory lines: serial clock, data in, data out, chip select.
// - Detects two- or three-byte memory addressing by trying two bytes on the signature, then three if that fails.
// - After fundamental reset releases, reads memory and loads registers before enumeration.
// - Memory is sixteen-bit words, reached through an eight-bit word address.
// - Auto-mode sequencer does word reads or writes from register start, address, command.
// - Word zero is read first; autoload runs only if it equals the signature.
// - Word one gives the byte count of the image.
// - Entries start at word two; address word holds dword address and port.
// - Next word is low half, following word high half of value.
// - Words are fetched in ascending order, each value written to its register.
// - Bit four at offset 87Ch reads one once autoload has finished.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module serial_eeprom_autoloader #(
  parameter logic [3:0] HALF_CYCLES = eeprom_loader_pkg::HALF_CYCLES
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, high active
  input wire logic link_clk, // Clock for the serial link logic
  input wire logic fundamental_reset_n, // Fundamental reset pin, low active
  input wire logic [11:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Low for the answering cycle
  output eeprom_loader_pkg::cfg_write_t cfg_wr, // Loaded register write
  output logic autoload_done, // Loader idle and finished
  output logic mem_serial_clk, // Serial clock to memory
  output logic mem_serial_in, // Data into memory
  output logic mem_chip_select_n, // Chip select, low active
  input wire logic mem_serial_out // Data out of memory
);

  eeprom_loader_pkg::core_regs_t q, d;
  logic link_ack_tgl;
  logic [15:0] link_rx;
  logic [15:0] rx_w;
  logic ack_ev;
  logic busy;
  logic [8:0] next_ptr;
  logic hit;
  logic commit;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bytes arrive low byte first, at the even byte address
  function automatic logic [15:0] swap(input logic [15:0] v);
    swap = {v[7:0], v[15:8]};
  endfunction

  // Builds one frame; word address doubles into a byte address
  function automatic eeprom_loader_pkg::link_cmd_t make_cmd(
    input logic [7:0] op,
    input logic wide,
    input logic [7:0] waddr,
    input logic [15:0] data
  );
    eeprom_loader_pkg::link_cmd_t c;
    c.bits = {op, 7'h00, waddr, 1'b0, swap(data), 8'h00};
    c.nbits = eeprom_loader_pkg::NBITS_NARROW;
    if (wide) begin
      c.bits = {op, 15'h0000, waddr, 1'b0, swap(data)};
      c.nbits = eeprom_loader_pkg::NBITS_WIDE;
    end
    if (op == eeprom_loader_pkg::OP_WREN) begin
      c.nbits = eeprom_loader_pkg::NBITS_OP;
    end
    make_cmd = c;
  endfunction

  // True when a whole entry at wptr lies inside the image and word range
  function automatic logic fits(input logic [8:0] wptr, input logic [15:0] size);
    logic [9:0] end_byte;
    end_byte = {wptr + eeprom_loader_pkg::ENTRY_WORDS, 1'b0};
    fits = (wptr <= eeprom_loader_pkg::LAST_ENTRY_WORD) && ({6'h00, end_byte} <= size);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link side

  // Serial link logic lives on its own clock behind a toggle handshake
  spi_word_engine #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_engine (
    .link_clk(link_clk),
    .rst(rst),
    .req_tgl(q.req_tgl),
    .cmd(q.cmd),
    .ack_tgl(link_ack_tgl),
    .rx_word(link_rx),
    .mem_serial_clk(mem_serial_clk),
    .mem_serial_in(mem_serial_in),
    .mem_chip_select_n(mem_chip_select_n),
    .mem_serial_out(mem_serial_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decodes used by the sequencer

  // Result word is stable once the ack toggle has crossed
  assign rx_w = swap(link_rx);
  assign ack_ev = q.ack_sync != q.ack_seen;
  // A frame is outstanding until its ack is seen; never toggle twice
  assign busy = q.req_tgl != q.ack_seen;
  assign next_ptr = q.ptr + eeprom_loader_pkg::ENTRY_WORDS;
  assign hit = avs_address == eeprom_loader_pkg::STATUS_OFS;
  // Write takes effect at the edge where the master sees waitrequest low
  assign commit = !q.waitreq && avs_write && hit;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and register slave

  always_comb begin
    d = q;
    d.cfg_wr.valid = 1'b0;
    d.waitreq = 1'b1;
    if (ack_ev) begin
      d.ack_seen = q.ack_sync;
    end
    if (!q.rstn_sync) begin
      // Held in fundamental reset: restart loading after release
      d.state = eeprom_loader_pkg::C_IDLE;
      d.sig_ok = 1'b0;
      d.addr3 = 1'b0;
    end else begin
      case (q.state)
        eeprom_loader_pkg::C_IDLE: begin
          // Wait out any frame that was cut off by the reset
          if (!busy) begin
            d.addr3 = 1'b0;
            d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, 1'b0,
                             eeprom_loader_pkg::SIG_WORD, 16'h0000);
            d.req_tgl = ~q.req_tgl;
            d.state = eeprom_loader_pkg::C_SIG;
          end
        end
        eeprom_loader_pkg::C_SIG: begin
          if (ack_ev) begin
            if (rx_w == eeprom_loader_pkg::SIGNATURE) begin
              d.sig_ok = 1'b1;
              d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, q.addr3,
                               eeprom_loader_pkg::SIZE_WORD, 16'h0000);
              d.req_tgl = ~q.req_tgl;
              d.state = eeprom_loader_pkg::C_SIZE;
            end else if (!q.addr3) begin
              // Two-byte try failed, retry with three address bytes
              d.addr3 = 1'b1;
              d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, 1'b1,
                               eeprom_loader_pkg::SIG_WORD, 16'h0000);
              d.req_tgl = ~q.req_tgl;
            end else begin
              d.state = eeprom_loader_pkg::C_DONE;
            end
          end
        end
        eeprom_loader_pkg::C_SIZE: begin
          if (ack_ev) begin
            d.size = rx_w;
            d.ptr = eeprom_loader_pkg::FIRST_ENTRY;
            d.state = eeprom_loader_pkg::C_DONE;
            if (fits(eeprom_loader_pkg::FIRST_ENTRY, rx_w)) begin
              d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, q.addr3,
                               eeprom_loader_pkg::FIRST_ENTRY[7:0], 16'h0000);
              d.req_tgl = ~q.req_tgl;
              d.state = eeprom_loader_pkg::C_ADDR;
            end
          end
        end
        eeprom_loader_pkg::C_ADDR: begin
          if (ack_ev) begin
            d.ent_addr = rx_w;
            d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, q.addr3,
                             q.ptr[7:0] + 8'h01, 16'h0000);
            d.req_tgl = ~q.req_tgl;
            d.state = eeprom_loader_pkg::C_LO;
          end
        end
        eeprom_loader_pkg::C_LO: begin
          if (ack_ev) begin
            d.ent_lo = rx_w;
            d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, q.addr3,
                             q.ptr[7:0] + 8'h02, 16'h0000);
            d.req_tgl = ~q.req_tgl;
            d.state = eeprom_loader_pkg::C_HI;
          end
        end
        eeprom_loader_pkg::C_HI: begin
          if (ack_ev) begin
            // Entry complete: one-cycle write strobe to the register file
            d.cfg_wr.valid = 1'b1;
            d.cfg_wr.port = q.ent_addr[15:10];
            d.cfg_wr.dword = q.ent_addr[9:0];
            d.cfg_wr.data = {rx_w, q.ent_lo};
            d.ptr = next_ptr;
            d.state = eeprom_loader_pkg::C_DONE;
            if (fits(next_ptr, q.size)) begin
              d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, q.addr3,
                               next_ptr[7:0], 16'h0000);
              d.req_tgl = ~q.req_tgl;
              d.state = eeprom_loader_pkg::C_ADDR;
            end
          end
        end
        eeprom_loader_pkg::C_DONE: begin
          // Idle; software starts auto-mode accesses from here
        end
        eeprom_loader_pkg::C_WREN: begin
          if (ack_ev) begin
            d.cmd = make_cmd(eeprom_loader_pkg::OP_WRITE, q.addr3,
                             q.ctl_waddr, q.ctl_data);
            d.req_tgl = ~q.req_tgl;
            d.state = eeprom_loader_pkg::C_AUTO;
          end
        end
        eeprom_loader_pkg::C_AUTO: begin
          if (ack_ev) begin
            if (!q.ctl_write) begin
              d.ctl_data = rx_w;
            end
            d.state = eeprom_loader_pkg::C_DONE;
          end
        end
        default: d.state = eeprom_loader_pkg::C_IDLE;
      endcase
    end

    // Register bus: request seen, answer in the next cycle
    if (!q.waitreq) begin
      if (commit) begin
        if (avs_byteenable[0]) begin
          d.ctl_write = avs_writedata[eeprom_loader_pkg::WRITE_BIT];
        end
        if (avs_byteenable[1]) begin
          d.ctl_waddr = avs_writedata[eeprom_loader_pkg::WADDR_LSB +: 8];
        end
        if (avs_byteenable[2]) begin
          d.ctl_data[7:0] = avs_writedata[eeprom_loader_pkg::DATA_LSB +: 8];
        end
        if (avs_byteenable[3]) begin
          d.ctl_data[15:8] = avs_writedata[eeprom_loader_pkg::DATA_LSB + 8 +: 8];
        end
        // A start outside the idle state is dropped; software polls first
        if (avs_byteenable[0] && avs_writedata[eeprom_loader_pkg::START_BIT] &&
            q.rstn_sync && q.state == eeprom_loader_pkg::C_DONE && !busy) begin
          if (avs_writedata[eeprom_loader_pkg::WRITE_BIT]) begin
            // Memory needs a write enable frame ahead of each write
            d.cmd = make_cmd(eeprom_loader_pkg::OP_WREN, q.addr3, 8'h00, 16'h0000);
            d.state = eeprom_loader_pkg::C_WREN;
          end else begin
            d.cmd = make_cmd(eeprom_loader_pkg::OP_READ, q.addr3,
                             d.ctl_waddr, 16'h0000);
            d.state = eeprom_loader_pkg::C_AUTO;
          end
          d.req_tgl = ~q.req_tgl;
        end
      end
    end else if (avs_read || avs_write) begin
      d.waitreq = 1'b0;
      d.rdata = 32'h0000_0000;
      if (hit) begin
        d.rdata[eeprom_loader_pkg::WRITE_BIT] = q.ctl_write;
        d.rdata[eeprom_loader_pkg::DONE_BIT] = q.done;
        d.rdata[eeprom_loader_pkg::WIDE_BIT] = q.addr3;
        d.rdata[eeprom_loader_pkg::SIG_BIT] = q.sig_ok;
        d.rdata[eeprom_loader_pkg::WADDR_LSB +: 8] = q.ctl_waddr;
        d.rdata[eeprom_loader_pkg::DATA_LSB +: 16] = q.ctl_data;
      end
    end

    // Completion flag follows the idle state, low during any access;
    // rises a cycle late so the last load write is never flagged as finished
    d.done = q.rstn_sync && (q.state == eeprom_loader_pkg::C_DONE) &&
             (d.state == eeprom_loader_pkg::C_DONE);

    if (rst) begin
      d = '0;
      d.waitreq = 1'b1;
    end
    // Synchronisers for the reset pin and the link ack toggle
    d.rstn_meta = fundamental_reset_n;
    d.rstn_sync = q.rstn_meta;
    d.ack_meta = link_ack_tgl;
    d.ack_sync = q.ack_meta;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign cfg_wr = q.cfg_wr;
  assign autoload_done = q.done;

endmodule

// ===== rtl/eeprom_loader_pkg.sv
// Constants, register layout and carrier types of the serial memory loader
package eeprom_loader_pkg;

  // Status and control register, byte address on the register bus
  localparam logic [11:0] STATUS_OFS = 12'h87C;
  localparam int START_BIT = 0;
  localparam int WRITE_BIT = 1;
  localparam int DONE_BIT = 4;
  localparam int WIDE_BIT = 5;
  localparam int SIG_BIT = 6;
  localparam int WADDR_LSB = 8;
  localparam int DATA_LSB = 16;

  // Image layout, in 16-bit word addresses of the memory
  localparam logic [15:0] SIGNATURE = 16'h1516;
  localparam logic [7:0] SIG_WORD = 8'h00;
  localparam logic [7:0] SIZE_WORD = 8'h01;
  localparam logic [8:0] FIRST_ENTRY = 9'h002;
  localparam logic [8:0] ENTRY_WORDS = 9'h003;
  localparam logic [8:0] LAST_ENTRY_WORD = 9'h0FD;

  // Serial memory opcodes and frame lengths in bits
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [5:0] NBITS_OP = 6'h08;
  localparam logic [5:0] NBITS_NARROW = 6'h28;
  localparam logic [5:0] NBITS_WIDE = 6'h30;

  // Link clock cycles per half period of the serial clock
  localparam logic [3:0] HALF_CYCLES = 4'h4;

  // One loaded configuration write
  typedef struct packed {
    logic valid;
    logic [5:0] port;
    logic [9:0] dword;
    logic [31:0] data;
  } cfg_write_t;

  // One serial frame: bits sent MSB first, and how many
  typedef struct packed {
    logic [47:0] bits;
    logic [5:0] nbits;
  } link_cmd_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'h0, C_SIG = 4'h1, C_SIZE = 4'h3, C_ADDR = 4'h2, C_LO = 4'h6,
    C_HI = 4'h7, C_DONE = 4'h5, C_WREN = 4'h4, C_AUTO = 4'hC
  } core_state_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'h0, L_LOW = 2'h1, L_HIGH = 2'h3, L_END = 2'h2
  } link_state_t;

  typedef struct packed {
    link_state_t state;
    logic rst_meta;
    logic rst_sync;
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic miso_meta;
    logic miso_sync;
    logic [3:0] cnt;
    logic [47:0] tx;
    logic [5:0] left;
    logic [15:0] rx;
    logic ack;
    logic sck;
    logic mosi;
    logic cs_n;
  } link_regs_t;

  typedef struct packed {
    core_state_t state;
    logic rstn_meta;
    logic rstn_sync;
    logic ack_meta;
    logic ack_sync;
    logic ack_seen;
    logic req_tgl;
    link_cmd_t cmd;
    logic addr3;
    logic sig_ok;
    logic done;
    logic [15:0] size;
    logic [8:0] ptr;
    logic [15:0] ent_addr;
    logic [15:0] ent_lo;
    cfg_write_t cfg_wr;
    logic ctl_write;
    logic [7:0] ctl_waddr;
    logic [15:0] ctl_data;
    logic waitreq;
    logic [31:0] rdata;
  } core_regs_t;

endpackage

// ===== rtl/spi_word_engine.sv
// Serial frame shifter running on the link clock
`timescale 1ns/1ps
module spi_word_engine #(
  parameter logic [3:0] HALF_CYCLES = eeprom_loader_pkg::HALF_CYCLES
) (
  input wire logic link_clk, // Link clock
  input wire logic rst, // Core reset, synchronised here
  input wire logic req_tgl, // Frame request toggle, core domain
  input wire eeprom_loader_pkg::link_cmd_t cmd, // Frame, stable while pending
  output logic ack_tgl, // Frame done toggle
  output logic [15:0] rx_word, // Last 16 bits shifted in
  output logic mem_serial_clk, // Serial clock to memory
  output logic mem_serial_in, // Data into memory
  output logic mem_chip_select_n, // Chip select, low active
  input wire logic mem_serial_out // Data out of memory
);

  eeprom_loader_pkg::link_regs_t q, d;

  // Frame shifter, serial clock divided from the link clock
  always_comb begin
    d = q;
    if (q.rst_sync) begin
      d = '0;
      d.cs_n = 1'b1;
    end else begin
      case (q.state)
        eeprom_loader_pkg::L_IDLE: begin
          // Command bus is stable once the toggle has crossed
          if (q.req_sync != q.req_seen) begin
            d.req_seen = q.req_sync;
            d.tx = cmd.bits;
            d.left = cmd.nbits;
            d.cs_n = 1'b0;
            d.mosi = cmd.bits[47];
            d.cnt = 4'h0;
            d.state = eeprom_loader_pkg::L_LOW;
          end
        end
        eeprom_loader_pkg::L_LOW: begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == HALF_CYCLES - 4'h1) begin
            d.cnt = 4'h0;
            d.sck = 1'b1;
            d.state = eeprom_loader_pkg::L_HIGH;
          end
        end
        eeprom_loader_pkg::L_HIGH: begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == HALF_CYCLES - 4'h1) begin
            // Synchronised data reflects the middle of the high phase
            d.cnt = 4'h0;
            d.sck = 1'b0;
            d.rx = {q.rx[14:0], q.miso_sync};
            d.tx = {q.tx[46:0], 1'b0};
            d.left = q.left - 6'h01;
            d.mosi = q.tx[46];
            d.state = eeprom_loader_pkg::L_LOW;
            if (q.left == 6'h01) begin
              d.mosi = 1'b0;
              d.state = eeprom_loader_pkg::L_END;
            end
          end
        end
        eeprom_loader_pkg::L_END: begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == HALF_CYCLES - 4'h1) begin
            d.cnt = 4'h0;
            d.cs_n = 1'b1;
            d.ack = ~q.ack;
            d.state = eeprom_loader_pkg::L_IDLE;
          end
        end
        default: d.state = eeprom_loader_pkg::L_IDLE;
      endcase
    end
    // Synchronisers, never reset
    d.rst_meta = rst;
    d.rst_sync = q.rst_meta;
    d.req_meta = req_tgl;
    d.req_sync = q.req_meta;
    d.miso_meta = mem_serial_out;
    d.miso_sync = q.miso_meta;
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign ack_tgl = q.ack;
  assign rx_word = q.rx;
  assign mem_serial_clk = q.sck;
  assign mem_serial_in = q.mosi;
  assign mem_chip_select_n = q.cs_n;

endmodule

// ===== test/serial_eeprom_autoloader_checker.sv
// Port assertions for the serial memory autoloader
`timescale 1ns/1ps
module serial_eeprom_autoloader_checker #(
  parameter logic [3:0] HALF_CYCLES = 4'h4
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Core reset
  input wire logic link_clk, // Link clock
  input wire logic fundamental_reset_n, // Fundamental reset pin
  input wire logic [11:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Wait request
  input wire eeprom_loader_pkg::cfg_write_t cfg_wr, // Loaded write
  input wire logic autoload_done, // Load finished
  input wire logic mem_serial_clk, // Serial clock
  input wire logic mem_serial_in, // Data into memory
  input wire logic mem_chip_select_n // Chip select, low active
);
  logic [3:0] high_q; // Link cycles the serial clock stayed high
  ////////////////////////////////////////
  // Width of the high phase; a 4-bit count covers every legal half period
  always_ff @(posedge link_clk) begin
    high_q <= mem_serial_clk ? high_q + 4'h1 : 4'h0;
  end
  ////////////////////////////////////////
  a_bus_answers: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_answer_once: assert property (@(posedge clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_caused: assert property (@(posedge clk) disable iff (rst)
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    avs_read && avs_waitrequest && avs_address != eeprom_loader_pkg::STATUS_OFS
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_start_reads_zero: assert property (@(posedge clk) disable iff (rst)
    avs_read && avs_waitrequest && avs_address == eeprom_loader_pkg::STATUS_OFS
    |=> !avs_readdata[0])
    else $error("start bit reads one");
  a_load_pulse: assert property (@(posedge clk) disable iff (rst)
    cfg_wr.valid |=> !cfg_wr.valid)
    else $error("load write longer than one cycle");
  a_load_busy: assert property (@(posedge clk) disable iff (rst)
    cfg_wr.valid |-> !autoload_done)
    else $error("load write while finished");
  a_done_held_low: assert property (@(posedge clk) disable iff (rst)
    !fundamental_reset_n [*6] |-> !autoload_done)
    else $error("finished while fundamental reset low");
  a_sck_idle: assert property (@(posedge link_clk) disable iff (rst)
    mem_chip_select_n |-> !mem_serial_clk)
    else $error("serial clock runs while deselected");
  a_sck_high_len: assert property (@(posedge link_clk) disable iff (rst)
    $fell(mem_serial_clk) |-> high_q == HALF_CYCLES)
    else $error("serial clock high phase wrong length");
  a_si_steady: assert property (@(posedge link_clk) disable iff (rst)
    mem_serial_clk && $past(mem_serial_clk) |-> $stable(mem_serial_in))
    else $error("data into memory moved while clock high");
endmodule

bind serial_eeprom_autoloader serial_eeprom_autoloader_checker #(
  .HALF_CYCLES(HALF_CYCLES)
) u_serial_eeprom_autoloader_checker (
  .clk(clk), .rst(rst), .link_clk(link_clk), .fundamental_reset_n(fundamental_reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfg_wr(cfg_wr),
  .autoload_done(autoload_done), .mem_serial_clk(mem_serial_clk),
  .mem_serial_in(mem_serial_in), .mem_chip_select_n(mem_chip_select_n)
);

// ===== test/spi_eeprom_model.sv
// Behavioural serial memory on the far side of the link
`timescale 1ns/1ps
module spi_eeprom_model (
  input wire logic sck, // Serial clock, mode 0
  input wire logic si, // Data into memory
  input wire logic cs_n, // Chip select, low active
  output logic so // Data out of memory
);
  logic [7:0] mem [0:511]; // Byte array, filled by the bench
  int abytes = 2; // Address bytes the part expects
  logic [7:0] op_q = 8'h00;
  logic [23:0] adr_q = 24'h0;
  logic [7:0] dat_q = 8'h00;
  logic wel_q = 1'b0;
  int n_q = 0;
  int k;
  int j;
  initial so = 1'b0;
  ////////////////////////////////////////
  // Opcode, address and write data taken on the rising clock
  always @(posedge sck) begin
    if (!cs_n) begin
      k = n_q - 8 - 8 * abytes;
      if (n_q < 8) begin
        op_q = {op_q[6:0], si};
      end else if (k < 0) begin
        adr_q = {adr_q[22:0], si};
      end else if (op_q == 8'h02 && wel_q) begin
        dat_q = {dat_q[6:0], si};
        if (k % 8 == 7) begin
          mem[9'(adr_q + k / 8)] = dat_q;
        end
      end
      n_q++;
    end
  end
  // Frame edges; a write without a prior enable frame is ignored
  always @(cs_n) begin
    if (!cs_n) begin
      n_q = 0;
    end else if (op_q == 8'h06 && n_q == 8) begin
      wel_q = 1'b1;
    end else if (op_q == 8'h02) begin
      wel_q = 1'b0;
    end
  end
  // Read data leaves on the falling clock; otherwise the line toggles
  always @(negedge sck or posedge cs_n) begin
    j = n_q - 8 - 8 * abytes;
    if (!cs_n && op_q == 8'h03 && j >= 0) begin
      so = mem[9'(adr_q + j / 8)][7 - j % 8];
    end else begin
      so = ~so;
    end
  end
endmodule

// ===== test/serial_eeprom_autoloader_test.sv
// Self-checking bench for the serial memory autoloader
`timescale 1ns/1ps
module serial_eeprom_autoloader_test;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic fundamental_reset_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  eeprom_loader_pkg::cfg_write_t cfg_wr;
  logic autoload_done;
  logic sck;
  logic si;
  logic cs_n;
  logic so;
  logic [31:0] rd;
  int errors = 0;
  int compares = 0;
  eeprom_loader_pkg::cfg_write_t seen_q [$];
  // Image: signature, 16-byte size, two entries, then one past the size
  logic [15:0] img [0:10] = '{16'h1516, 16'h0010, 16'h1523, 16'hBEEF, 16'hDEAD,
    16'hFFFF, 16'h0001, 16'h8000, 16'h0404, 16'h1111, 16'h2222};
  always #4 clk = ~clk;
  // Link clock offset so its edges never line up with the core clock edges
  initial begin
    #1.3;
    forever #6 link_clk = ~link_clk;
  end
  serial_eeprom_autoloader u_serial_eeprom_autoloader (
    .clk(clk), .rst(rst), .link_clk(link_clk), .fundamental_reset_n(fundamental_reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfg_wr(cfg_wr),
    .autoload_done(autoload_done), .mem_serial_clk(sck), .mem_serial_in(si),
    .mem_chip_select_n(cs_n), .mem_serial_out(so));
  spi_eeprom_model u_spi_eeprom_model (.sck(sck), .si(si), .cs_n(cs_n), .so(so));
  ////////////////////////////////////////
  // Collect every loaded register write
  always @(posedge clk) begin
    if (cfg_wr.valid === 1'b1) begin
      seen_q.push_back(cfg_wr);
    end
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Poll the finished bit; leaves the last status word in rd
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, eeprom_loader_pkg::STATUS_OFS, 32'h0, rd);
      n++;
    end while (rd[eeprom_loader_pkg::DONE_BIT] !== 1'b1 && n < 5000);
    if (rd[eeprom_loader_pkg::DONE_BIT] !== 1'b1) errors++; // Poll limit ran out
  endtask
  task automatic auto(input logic wr, input logic [7:0] w, input logic [15:0] d);
    bus(1'b1, eeprom_loader_pkg::STATUS_OFS, {d, w, 6'h00, wr, 1'b1}, rd);
    wait_done();
  endtask
  // Pulse the fundamental reset and compare the whole autoload
  task automatic load(input logic [31:0] mask, input logic [31:0] exp, input int n);
    seen_q.delete();
    fundamental_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    check("done in reset", 1'b0, autoload_done);
    fundamental_reset_n <= 1'b1;
    wait_done();
    check("status", exp, rd & mask);
    check("entries", n, seen_q.size());
    for (int i = 0; i < n; i++) begin
      check("entry", {1'b1, img[2+3*i], img[4+3*i], img[3+3*i]}, seen_q[i]);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    foreach (u_spi_eeprom_model.mem[i]) begin
      u_spi_eeprom_model.mem[i] = 8'hFF;
    end
    foreach (img[i]) begin
      u_spi_eeprom_model.mem[2*i] = img[i][7:0];
      u_spi_eeprom_model.mem[2*i+1] = img[i][15:8];
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    load(32'h71, 32'h50, 2);
    auto(1'b0, 8'h06, 16'h0000);
    check("read word", img[6], rd[31:16]);
    auto(1'b1, 8'hFF, 16'hA55A);
    check("low byte", 8'h5A, u_spi_eeprom_model.mem[510]);
    check("high byte", 8'hA5, u_spi_eeprom_model.mem[511]);
    auto(1'b0, 8'hFF, 16'h0000);
    check("read back", 16'hA55A, rd[31:16]);
    bus(1'b0, 12'h880, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    u_spi_eeprom_model.abytes = 3;
    load(32'h71, 32'h70, 2);
    u_spi_eeprom_model.mem[0] = 8'h17;
    load(32'h51, 32'h10, 0);
    complete_run();
  end
  // Cut a hang short well after the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule
